// File: dgh_debounce.sv
module dgh_debounce (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic clr_i,
   input  wire logic bypass_i,
   input  wire logic sample_i,
   input  wire logic raw_i,
   // Result
   output logic      stable_o
);
   import dgh_pkg::*;

   logic [2:0] cnt_reg, cnt_next;
   logic       out_reg, out_next;

   // Eight agreeing samples are needed, so the window is 8 sample periods
   always_comb begin
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (clr_i) begin
         cnt_next = 3'h0;
         out_next = 1'b0;
      end else if (bypass_i) begin
         cnt_next = 3'h0;
         out_next = raw_i;
      end else if (sample_i) begin
         if (raw_i == out_reg) begin
            cnt_next = 3'h0;
         end else if (cnt_reg == DGH_DB_LAST) begin
            cnt_next = 3'h0;
            out_next = raw_i;
         end else begin
            cnt_next = cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 3'h0;
         out_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign stable_o = out_reg;

endmodule // dgh_debounce

// File: dgh_host_model.sv
module dgh_host_model (
   // Clock
   input  wire logic         clk_i,
   // Control port
   output dgh_pkg::dgh_req_t req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import dgh_pkg::*;

   // Extra idle cycles before each request, to act slow
   int idle_cyc = 0;

   initial req_o = '0;

   // ----------------------------------------
   // One byte transfer
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] pg, input logic [6:0] a,
                       input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (w && a == DGH_ADDR_RGAIN && $signed(v) > DGH_GAIN_MAX) begin
         v = DGH_GAIN_MAX;
      end
      if (w && a == DGH_ADDR_CMP1) begin
         v[7] = 1'b0;
      end
      if (w && a == DGH_ADDR_CMP2) begin
         v = v & 8'h78;
      end
      repeat (idle_cyc) @(posedge clk_i);
      @(posedge clk_i);
      #1;
      req_o = '{wr: w, rd: !w, page: pg, addr: a, wdata: v};
      @(posedge clk_i);
      #1;
      // Released fields flip so a stale value never looks valid
      req_o = '{wr: 1'b0, rd: 1'b0, page: ~pg, addr: ~a, wdata: ~v};
   endtask

endmodule // dgh_host_model

// File: dgh_pkg.sv
package dgh_pkg;

   // ----------------------------------------
   // Register map, page 0
   // ----------------------------------------
   localparam logic [7:0] DGH_PAGE_MAIN   = 8'h00;
   localparam logic [6:0] DGH_ADDR_RGAIN  = 7'h42;
   localparam logic [6:0] DGH_ADDR_HSDET  = 7'h43;
   localparam logic [6:0] DGH_ADDR_CMP1   = 7'h44;
   localparam logic [6:0] DGH_ADDR_CMP2   = 7'h45;

   localparam logic [7:0] DGH_RST_RGAIN   = 8'h00;
   localparam logic [7:0] DGH_RST_HSDET   = 8'h00;
   localparam logic [7:0] DGH_RST_CMP1    = 8'h0f;
   localparam logic [7:0] DGH_RST_CMP2    = 8'h38;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int DGH_HS_EN_BIT      = 7;
   localparam int DGH_HS_STAT_LSB    = 5;
   localparam int DGH_HS_INS_LSB     = 2;
   localparam int DGH_HS_BTN_LSB     = 0;
   localparam int DGH_CMP_LEN_BIT    = 6;
   localparam int DGH_CMP_REN_BIT    = 5;
   localparam int DGH_CMP_THR_LSB    = 2;
   localparam int DGH_CMP_HYS_LSB    = 0;
   localparam int DGH_CMP_HOLD_LSB   = 3;

   // ----------------------------------------
   // Gain, status and timing constants
   // ----------------------------------------
   localparam logic signed [7:0] DGH_GAIN_MAX = 8'sh30;
   localparam logic [1:0] DGH_HS_NONE   = 2'h0;
   localparam logic [1:0] DGH_HS_NOMIC  = 2'h1;
   localparam logic [1:0] DGH_HS_MIC    = 2'h3;
   localparam int DGH_REF_FREQ_HZ       = 1000000;
   localparam int DGH_MS_PER_S          = 1000;
   localparam int DGH_REF_PER_MS        = DGH_REF_FREQ_HZ / DGH_MS_PER_S;
   localparam logic [9:0] DGH_REF_LAST  = 10'(DGH_REF_PER_MS - 1);
   localparam logic [2:0] DGH_INS_LAST  = 3'h5;
   localparam logic [2:0] DGH_DB_LAST   = 3'h7;
   localparam logic [17:0] DGH_HOLD_BASE = 18'h00020;
   localparam logic [17:0] DGH_HOLD_14   = 18'h20000;
   localparam logic [17:0] DGH_HOLD_15   = 18'h28000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dgh_req_t;

   typedef struct packed {
      logic              left_en;
      logic              right_en;
      logic signed [5:0] thresh_db;
      logic [1:0]        hyst_db;
      logic [17:0]       hold_words;
   } dgh_cmp_t;

endpackage

// File: dgh_regs.sv
// How it works
// - Four byte registers, page 0, 66-69
// - Gain is signed half-dB, resets zero
// - Code zero unity, each step 0.5 dB
// - Detection runs only while enable set
// - Status 00 none, 01 plain, 11 mic
// - Insertion debounce 16 to 512 ms
// - Button debounce none, 8, 16, 32 ms
// - All debounce timing from 1 MHz reference
// - Per-channel compression enables, reset off
// - Threshold -3 dB steps, resets 011
// - Hysteresis equals field dB, resets 11
// - Hold off at 0, else word clocks
module dgh_regs (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Control port
   input  wire dgh_pkg::dgh_req_t   req_i,
   output logic [7:0]               rdata_o,
   output logic                     rack_o,
   // Timing enables
   input  wire logic                ref_tick_i,
   input  wire logic                wclk_tick_i,
   // Headset pins
   input  wire logic                hs_plug_i,
   input  wire logic                hs_mic_i,
   input  wire logic                hs_btn_i,
   // Audio path settings and status
   output logic signed [7:0]        r_gain_o,
   output dgh_pkg::dgh_cmp_t        cmp_o,
   output logic                     hold_restart_ack_o,
   input  wire logic                hold_restart_i,
   output logic                     hold_active_o,
   output logic                     hs_button_o
);
   import dgh_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic hit(input logic [5:0] ms, input logic [2:0] k);
      logic [5:0] mask;
      mask = 6'((7'h01 << k) - 7'h01);
      return (ms & mask) == 6'h00;
   endfunction

   function automatic logic [17:0] hold_len(input logic [3:0] c);
      logic [17:0] v;
      v = DGH_HOLD_BASE << (c - 4'h1);
      if (c == 4'h0) v = 18'h0;
      else if (c == 4'he) v = DGH_HOLD_14;
      else if (c == 4'hf) v = DGH_HOLD_15;
      return v;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0]  gain_reg, gain_next;
   logic [7:0]  hs_reg, hs_next;
   logic [7:0]  c1_reg, c1_next;
   logic [3:0]  hold_reg, hold_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        rack_reg, rack_next;
   logic [1:0]  stat_reg, stat_next;
   logic        hit0;
   logic [7:0]  rd_mux;

   assign hit0 = req_i.page == DGH_PAGE_MAIN;

   always_comb begin
      rd_mux = 8'h00;
      if (req_i.addr == DGH_ADDR_RGAIN) begin
         rd_mux = gain_reg;
      end else if (req_i.addr == DGH_ADDR_HSDET) begin
         rd_mux = {hs_reg[7], stat_reg, hs_reg[4:0]};
      end else if (req_i.addr == DGH_ADDR_CMP1) begin
         rd_mux = c1_reg;
      end else if (req_i.addr == DGH_ADDR_CMP2) begin
         rd_mux = {1'b0, hold_reg, 3'h0};
      end
   end

   always_comb begin
      gain_next  = gain_reg;
      hs_next    = hs_reg;
      c1_next    = c1_reg;
      hold_next  = hold_reg;
      rack_next  = req_i.rd;
      rdata_next = req_i.rd ? (hit0 ? rd_mux : 8'h00) : rdata_reg;
      if (req_i.wr && hit0) begin
         if (req_i.addr == DGH_ADDR_RGAIN) begin
            gain_next = req_i.wdata;
         end else if (req_i.addr == DGH_ADDR_HSDET) begin
            hs_next = {req_i.wdata[7], 2'b00, req_i.wdata[4:0]};
         end else if (req_i.addr == DGH_ADDR_CMP1) begin
            c1_next = req_i.wdata;
         end else if (req_i.addr == DGH_ADDR_CMP2) begin
            hold_next = req_i.wdata[6:3];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_reg  <= DGH_RST_RGAIN;
         hs_reg    <= DGH_RST_HSDET;
         c1_reg    <= DGH_RST_CMP1;
         hold_reg  <= DGH_RST_CMP2[6:3];
         rdata_reg <= 8'h00;
         rack_reg  <= 1'b0;
      end else begin
         gain_reg  <= gain_next;
         hs_reg    <= hs_next;
         c1_reg    <= c1_next;
         hold_reg  <= hold_next;
         rdata_reg <= rdata_next;
         rack_reg  <= rack_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign rack_o  = rack_reg;

   // ----------------------------------------
   // Decoded settings
   // ----------------------------------------
   logic signed [7:0] rg_reg, rg_next;
   dgh_cmp_t          cmp_reg, cmp_next;
   logic [5:0]        thr_step;

   always_comb begin
      // Reserved positive codes clamp rather than overdrive the path
      rg_next = ($signed(gain_reg) > DGH_GAIN_MAX) ? DGH_GAIN_MAX
                                                   : $signed(gain_reg);
      thr_step = {3'h0, c1_reg[4:2]} + 6'h01;
      cmp_next.left_en    = c1_reg[DGH_CMP_LEN_BIT];
      cmp_next.right_en   = c1_reg[DGH_CMP_REN_BIT];
      cmp_next.thresh_db  = $signed(6'h00 - (thr_step + thr_step + thr_step));
      cmp_next.hyst_db    = c1_reg[1:0];
      cmp_next.hold_words = hold_len(hold_reg);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rg_reg  <= 8'sh00;
         cmp_reg <= '0;
      end else begin
         rg_reg  <= rg_next;
         cmp_reg <= cmp_next;
      end
   end

   assign r_gain_o = rg_reg;
   assign cmp_o    = cmp_reg;

   // ----------------------------------------
   // Hold timer in word clocks
   // ----------------------------------------
   logic [17:0] hcnt_reg, hcnt_next;
   logic        hact_reg, hact_next;
   logic        hack_reg, hack_next;

   always_comb begin
      hcnt_next = hcnt_reg;
      if (hold_restart_i) begin
         hcnt_next = cmp_reg.hold_words;
      end else if (wclk_tick_i && hcnt_reg != 18'h0) begin
         hcnt_next = hcnt_reg - 18'h1;
      end
      hact_next = hcnt_next != 18'h0;
      hack_next = hold_restart_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hcnt_reg <= 18'h0;
         hact_reg <= 1'b0;
         hack_reg <= 1'b0;
      end else begin
         hcnt_reg <= hcnt_next;
         hact_reg <= hact_next;
         hack_reg <= hack_next;
      end
   end

   assign hold_active_o      = hact_reg;
   assign hold_restart_ack_o = hack_reg;

   // ----------------------------------------
   // Headset detection
   // ----------------------------------------
   logic [2:0] sy1_reg, sy2_reg;
   logic [9:0] ref_reg, ref_next;
   logic [5:0] ms_reg, ms_next;
   logic       mst_reg, mst_next;
   logic       det_en, ins_smp, btn_smp, btn_byp;
   logic [2:0] ins_k, btn_k;
   logic       plug_db, mic_db, btn_db;
   logic       btn_reg, btn_next;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sy1_reg <= 3'h0;
         sy2_reg <= 3'h0;
      end else begin
         sy1_reg <= {hs_btn_i, hs_mic_i, hs_plug_i};
         sy2_reg <= sy1_reg;
      end
   end

   always_comb begin
      det_en   = hs_reg[DGH_HS_EN_BIT];
      ref_next = ref_reg;
      ms_next  = ms_reg;
      mst_next = 1'b0;
      if (!det_en) begin
         ref_next = 10'h0;
         ms_next  = 6'h0;
      end else if (ref_tick_i) begin
         if (ref_reg == DGH_REF_LAST) begin
            ref_next = 10'h0;
            mst_next = 1'b1;
            ms_next  = ms_reg + 6'h01;
         end else begin
            ref_next = ref_reg + 10'h1;
         end
      end
      // Reserved insertion codes behave as the slowest setting
      ins_k   = ((hs_reg[4:2] > DGH_INS_LAST) ? DGH_INS_LAST : hs_reg[4:2]) + 3'h1;
      btn_k   = {1'b0, hs_reg[1:0]} - 3'h1;
      btn_byp = hs_reg[1:0] == 2'h0;
      ins_smp = mst_reg && hit(ms_reg, ins_k);
      btn_smp = mst_reg && hit(ms_reg, btn_k);
      stat_next = !plug_db ? DGH_HS_NONE : (mic_db ? DGH_HS_MIC : DGH_HS_NOMIC);
      btn_next  = plug_db && btn_db;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_reg  <= 10'h0;
         ms_reg   <= 6'h0;
         mst_reg  <= 1'b0;
         stat_reg <= DGH_HS_NONE;
         btn_reg  <= 1'b0;
      end else begin
         ref_reg  <= ref_next;
         ms_reg   <= ms_next;
         mst_reg  <= mst_next;
         stat_reg <= stat_next;
         btn_reg  <= btn_next;
      end
   end

   assign hs_button_o = btn_reg;

   dgh_debounce u_plug (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (!det_en),
      .bypass_i (1'b0),
      .sample_i (ins_smp),
      .raw_i    (sy2_reg[0]),
      .stable_o (plug_db)
   );

   dgh_debounce u_mic (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (!det_en),
      .bypass_i (1'b0),
      .sample_i (ins_smp),
      .raw_i    (sy2_reg[1]),
      .stable_o (mic_db)
   );

   dgh_debounce u_btn (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (!det_en),
      .bypass_i (btn_byp),
      .sample_i (btn_smp),
      .raw_i    (sy2_reg[2]),
      .stable_o (btn_db)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_gain_wr;
      req_i.wr && hit0 && req_i.addr == DGH_ADDR_RGAIN
         && $signed(req_i.wdata) <= DGH_GAIN_MAX;
   endsequence

   AST_GAIN_TRACK: assert property (s_gain_wr |-> ##2 r_gain_o == $signed($past(req_i.wdata, 2)))
      else $error("gain output does not follow written code");
   AST_GAIN_CAP: assert property (r_gain_o <= DGH_GAIN_MAX)
      else $error("gain output above +24 dB");
   AST_DET_IDLE: assert property (!det_en [*3] |-> stat_reg == DGH_HS_NONE && !mst_reg)
      else $error("detection active while disabled");
   AST_NO_RSVD: assert property (stat_reg != 2'h2)
      else $error("reserved headset status shown");
   AST_STAT_CAUSE: assert property ($changed(stat_reg) |-> $past(ins_smp, 2) || !$past(det_en, 2))
      else $error("status moved without a debounce sample");
   AST_MS_REF: assert property (mst_reg |-> $past(ref_tick_i) && $past(ref_reg) == DGH_REF_LAST)
      else $error("millisecond tick without reference count");
   AST_CMP_EN: assert property (req_i.wr && hit0 && req_i.addr == DGH_ADDR_CMP1 |-> ##2
                                cmp_o.left_en == $past(req_i.wdata[6], 2)
                                && cmp_o.right_en == $past(req_i.wdata[5], 2))
      else $error("compression enables not applied");
   AST_HOLD_OFF: assert property (hold_restart_i && cmp_reg.hold_words == 18'h0 |=> ##1 !hold_active_o)
      else $error("hold active while hold disabled");
   AST_READ_ACK: assert property (req_i.rd |=> rack_o)
      else $error("read not answered");

endmodule // dgh_regs

// File: tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dgh_pkg::*;

   logic              clk_i;
   logic              rst_i;
   logic              ref_tick_i;
   logic              wclk_tick_i;
   logic              hs_plug_i;
   logic              hs_mic_i;
   logic              hs_btn_i;
   logic              hold_restart_i;
   dgh_req_t          req_i;
   logic [7:0]        rdata_o;
   logic              rack_o;
   logic              hold_restart_ack_o;
   logic              hold_active_o;
   logic              hs_button_o;
   logic signed [7:0] r_gain_o;
   dgh_cmp_t          cmp_o;
   int                n_fail = 0;
   int                tests_run = 0;
   int                cycles = 0;
   int                seed = 32'he829;
   logic [7:0]        exp_q[$];
   logic [7:0]        gtab[3] = '{8'h30, 8'h81, 8'hff};

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   dgh_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
      .rack_o(rack_o), .ref_tick_i(ref_tick_i), .wclk_tick_i(wclk_tick_i),
      .hs_plug_i(hs_plug_i), .hs_mic_i(hs_mic_i), .hs_btn_i(hs_btn_i),
      .r_gain_o(r_gain_o), .cmp_o(cmp_o), .hold_restart_ack_o(hold_restart_ack_o),
      .hold_restart_i(hold_restart_i), .hold_active_o(hold_active_o),
      .hs_button_o(hs_button_o));

   dgh_host_model hm_u (.clk_i(clk_i), .req_o(req_i));

   // ----------------------------------------
   // Checking and reporting
   // ----------------------------------------
   task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      if (rack_o === 1'b1) begin
         if (exp_q.size() == 0) check(18'(rdata_o), 18'h3ffff, "stray read answer");
         else check(18'(rdata_o), 18'(exp_q.pop_front()), "read data");
      end
   end

   // Whole run is about 41 ms of 1 ms ticks
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 50000) begin
         n_fail++;
         conclude();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      hm_u.xfer(1'b1, DGH_PAGE_MAIN, a, d);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e,
                     input logic [7:0] pg = DGH_PAGE_MAIN);
      exp_q.push_back(e);
      hm_u.xfer(1'b0, pg, a, 8'h00);
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic ms(input int n);
      repeat (n * 1000) @(posedge clk_i);
      #1;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         wclk_tick_i = 1'b1;
         @(posedge clk_i);
         #1;
         wclk_tick_i = 1'b0;
         @(posedge clk_i);
         #1;
      end
   endtask

   task automatic restart(input logic act);
      hold_restart_i = 1'b1;
      @(posedge clk_i);
      #1;
      hold_restart_i = 1'b0;
      check(18'({hold_restart_ack_o, hold_active_o}), 18'({1'b1, act}), "restart");
      @(posedge clk_i);
      #1;
      check(18'(hold_restart_ack_o), 18'h0, "restart ack pulse");
   endtask

   function automatic logic [17:0] cmpv();
      return 18'({cmp_o.left_en, cmp_o.right_en, cmp_o.thresh_db, cmp_o.hyst_db});
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] g;
      int         e;
      rst_i = 1'b1;
      ref_tick_i = 1'b1;
      wclk_tick_i = 1'b0;
      hs_plug_i = 1'b0;
      hs_mic_i = 1'b0;
      hs_btn_i = 1'b0;
      hold_restart_i = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      @(posedge clk_i);
      #1;
      check(cmpv(), 18'({2'b00, 6'h34, 2'h3}), "cmp reset");
      check(18'(cmp_o.hold_words), 18'h00800, "hold reset");
      rd(DGH_ADDR_RGAIN, 8'h00);
      rd(DGH_ADDR_HSDET, 8'h00);
      rd(DGH_ADDR_CMP1, 8'h0f);
      rd(DGH_ADDR_CMP2, 8'h38);
      rd(7'h46, 8'h00);
      hm_u.xfer(1'b1, 8'h01, DGH_ADDR_RGAIN, 8'h55);
      rd(DGH_ADDR_RGAIN, 8'h00, 8'h01);
      rd(DGH_ADDR_RGAIN, 8'h00);
      for (int i = 0; i < 9; i++) begin
         g = (i < 3) ? gtab[i] : 8'({$random(seed)} % 176 - 127);
         wr(DGH_ADDR_RGAIN, g);
         settle();
         check({10'h0, r_gain_o}, 18'(g), "gain");
         rd(DGH_ADDR_RGAIN, g);
      end
      for (int t = 0; t < 8; t++) begin
         wr(DGH_ADDR_CMP1, 8'({t[0], t[1], t[2:0], t[1:0]}));
         settle();
         check(cmpv(), 18'({t[0], t[1], 6'(-3 * (t + 1)), t[1:0]}), "cmp");
         rd(DGH_ADDR_CMP1, 8'({t[0], t[1], t[2:0], t[1:0]}));
      end
      hm_u.idle_cyc = 2;
      for (int k = 0; k < 16; k++) begin
         wr(DGH_ADDR_CMP2, 8'(k << 3));
         settle();
         e = (k == 0) ? 0 : (k == 14) ? 32'h20000 : (k == 15) ? 32'h28000 : 32 << (k - 1);
         check(18'(cmp_o.hold_words), 18'(e), "hold words");
         rd(DGH_ADDR_CMP2, 8'(k << 3));
      end
      hm_u.idle_cyc = 0;
      wr(DGH_ADDR_CMP2, 8'h00);
      settle();
      restart(1'b0);
      wr(DGH_ADDR_CMP2, 8'h08);
      settle();
      restart(1'b1);
      ticks(31);
      check(18'(hold_active_o), 18'h1, "hold still active");
      ticks(1);
      check(18'(hold_active_o), 18'h0, "hold ended");
      hs_plug_i = 1'b1;
      hs_mic_i = 1'b1;
      hs_btn_i = 1'b1;
      ms(1);
      rd(DGH_ADDR_HSDET, 8'h00);
      wr(DGH_ADDR_HSDET, 8'h85);
      // Paused reference must stall the debounce clock
      ref_tick_i = 1'b0;
      ms(5);
      ref_tick_i = 1'b1;
      ms(29);
      rd(DGH_ADDR_HSDET, 8'h85);
      check(18'(hs_button_o), 18'h0, "button early");
      ms(6);
      rd(DGH_ADDR_HSDET, 8'he5);
      check(18'(hs_button_o), 18'h1, "button");
      wr(DGH_ADDR_HSDET, 8'h05);
      settle();
      rd(DGH_ADDR_HSDET, 8'h05);
      check(18'(hs_button_o), 18'h0, "button off");
      repeat (4) @(posedge clk_i);
      check(18'(exp_q.size()), 18'h0, "reads answered");
      conclude();
   end
endmodule // tb_top
